// ===== dv/tbf_link_props.sv
/*
 * Checker for the reader-card link: downlink run lengths and subcarrier.
 * Assumes it sits beside the link interface in the bench top.
 */
module tbf_link_props (
	// Reader domain
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic [1:0] rate_i,
	// Link
	input  wire logic       link_clk,
	input  wire logic       pon_rst,
	input  wire logic       mod,
	input  wire logic       lm
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------------
	// Run lengths
	// ------------------------------------------------------------------
	int bt;
	int hi;
	int lo;
	int nseg;
	int quiet;
	assign bt = 256 >> rate_i;
	// lo and quiet saturate, hi does not; reset and power-on look like a long idle gap
	always_ff @(posedge clk_i) begin
		if (srst_i || pon_rst) begin
			hi    <= 0;
			lo    <= 65536;
			nseg  <= 0;
			quiet <= 65536;
		end else begin
			hi    <= mod ? hi + 1 : 0;
			lo    <= mod ? 0 : (lo < 65536 ? lo + 1 : lo);
			quiet <= lm ? 0 : (quiet < 65536 ? quiet + 1 : quiet);
			if (mod && hi == 0) begin
				nseg <= (lo >= 12 * bt) ? 1 : nseg + 1;
			end else if (!mod && lo == 0) begin
				nseg <= nseg + 1;
			end
		end
	end
	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_link_clk_div: assert property (@(posedge clk_i) disable iff (srst_i)
		!$past(srst_i) |-> link_clk != $past(link_clk))
		else $error("link clock not half of reader clock");
	a_one_talker: assert property (@(posedge clk_i) disable iff (srst_i)
		$rose(mod) |-> quiet > 2)
		else $error("reader sends while card replies");
	a_high_whole_bits: assert property (@(posedge clk_i) disable iff (srst_i)
		$fell(mod) |-> hi % bt == 0 && hi >= bt && hi <= 10 * bt)
		else $error("modulated run not whole bits");
	a_low_whole_bits: assert property (@(posedge clk_i) disable iff (srst_i)
		$rose(mod) && lo < 12 * bt |-> lo % bt == 0 && lo >= bt)
		else $error("unmodulated run not whole bits");
	a_sof_ten_bits: assert property (@(posedge clk_i) disable iff (srst_i)
		$fell(mod) && nseg == 1 |-> hi == 10 * bt)
		else $error("start delimiter length wrong");
	a_sof_two_stops: assert property (@(posedge clk_i) disable iff (srst_i)
		$rose(mod) && nseg == 2 |-> lo == 2 * bt)
		else $error("stop bits after start delimiter wrong");
	a_sub_low_half: assert property (@(posedge link_clk) disable iff (pon_rst)
		$fell(lm) |-> !lm [*8])
		else $error("subcarrier low half too short");
	a_sub_high_max: assert property (@(posedge link_clk) disable iff (pon_rst)
		$rose(lm) |-> ##[1:16] !lm)
		else $error("subcarrier high run too long");
	// Main scenarios
	c_sof: cover property (@(posedge clk_i) $fell(mod) && nseg == 1);
	c_reply: cover property (@(posedge link_clk) $rose(lm));
	c_flip: cover property (@(posedge link_clk) $rose(lm) ##1 lm [*8] ##1 lm);
endmodule

// ===== dv/tbf_tb.sv
/*
 * Bench: reader and card joined by the link; commands at three rates.
 * Assumes the design sources and tbf_link_props are compiled first.
 */
module tbf_tb;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
	$display("mismatch %s exp %h got %h", nm, e, a); end end
	// ------------------------------------------------------------------
	// Signals and identifier straps (values arbitrary)
	// ------------------------------------------------------------------
	localparam logic [35:0] SERIAL = 36'h9_a5c3_1e7f;
	localparam logic [7:0]  FEAT   = 8'h5a;
	localparam logic [7:0]  MFR    = 8'h3c;
	localparam logic [7:0]  CLS    = 8'hc6;
	localparam logic [63:0] UID    = {CLS, MFR, 4'h0, FEAT, SERIAL};
	logic        clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [1:0]  rate_i = 2'h3;
	logic        start_i = 1'b0;
	logic [7:0]  cmd_i = 8'h00;
	logic        busy_o;
	logic        rsp_valid_o;
	logic        rsp_ok_o;
	logic [71:0] rsp_data_o;
	logic [7:0]  cmd_o;
	logic        card_busy;
	logic [7:0]  last = 8'h00;
	int          n_mismatch = 0;
	int          n_compared = 0;
	tbf_link_if lnk();
	tbf_reader #(.RSP_TIMEOUT(21000)) u_tbf_reader (.clk_i, .srst_i, .lnk(lnk), .rate_i,
		.start_i, .cmd_i, .busy_o, .rsp_valid_o, .rsp_ok_o, .rsp_data_o);
	tbf_card #(.GUARD_BITS(4)) u_tbf_card (.lnk(lnk), .serial_i(SERIAL), .feature_i(FEAT),
		.mfr_i(MFR), .class_i(CLS), .rate_i, .cmd_o, .busy_o(card_busy));
	tbf_link_props u_tbf_link_props (.clk_i, .srst_i, .rate_i, .link_clk(lnk.link_clk),
		.pon_rst(lnk.pon_rst), .mod(lnk.mod), .lm(lnk.lm));
	always #25 clk_i = ~clk_i;
	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic stop_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// One command frame and its reply; a refused command ends by timeout
	task automatic xfer(input logic [1:0] r, input logic [7:0] c, input logic [7:0] h,
		input logic ok);
		int n;
		rate_i <= r;
		cmd_i <= c;
		start_i <= 1'b1;
		// Hold the request until the reader shows that it was taken
		do begin
			@(posedge clk_i);
		end while (busy_o !== 1'b1);
		start_i <= 1'b0;
		n = 0;
		while (rsp_valid_o !== 1'b1 && n < 40000) begin
			@(posedge clk_i);
			n++;
		end
		`CHK("valid", 1'b1, rsp_valid_o)
		`CHK("ok", ok, rsp_ok_o)
		`CHK("card busy", ok, card_busy)
		if (ok) begin
			`CHK("data", {UID, h}, rsp_data_o)
			last = c;
		end
		`CHK("cmd", last, cmd_o)
		$display("test cmd %h rate %0d done", c, r);
	endtask
	// ------------------------------------------------------------------
	// Sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		repeat (40) @(posedge clk_i);
		xfer(2'h3, 8'h05, 8'h50, 1'b1);
		xfer(2'h3, 8'h31, 8'h00, 1'b1);
		xfer(2'h3, 8'h32, 8'h00, 1'b1);
		xfer(2'h3, 8'h07, 8'h00, 1'b0);
		xfer(2'h2, 8'h05, 8'h50, 1'b1);
		xfer(2'h1, 8'h31, 8'h00, 1'b1);
		stop_test();
	end
	initial begin
		repeat (95000) @(posedge clk_i);
		n_mismatch++;
		stop_test();
	end
endmodule

// ===== src/tbf_card.sv
/*
 * Card end: receives downlink frames, checks them and answers with the
 * identifier as a BPSK subcarrier reply.
 * Assumes the carrier runs as link_clk and pon_rst is held several carrier
 * cycles; rate_i and identifier straps are steady in the carrier domain.
 */
`include "tbf_defines.svh"
module tbf_card
	import tbf_pkg::*;
#(
	parameter int GUARD_BITS = `TBF_GUARD_BITS
)
(
	// Link
	tbf_link_if.card             lnk,
	// Identifier straps
	input  wire logic [35:0]     serial_i,
	input  wire logic [7:0]      feature_i,
	input  wire logic [7:0]      mfr_i,
	input  wire logic [7:0]      class_i,
	// Data rate: bit = 8 >> rate_i subcarrier periods
	input  wire logic [1:0]      rate_i,
	// Status
	output logic [7:0]           cmd_o,
	output logic                 busy_o
);
	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	if (GUARD_BITS < 1 || GUARD_BITS > 16) begin : g_chk
		$error("GUARD_BITS must be 1 to 16");
	end

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic        mod_s1;
		logic        mod_s2;
		logic [1:0]  rate_s1;
		logic [1:0]  rate_s2;
		logic        rprev;
		tbf_rx_t     rxs;
		logic [6:0]  rcnt;
		logic [3:0]  rbit;
		logic [9:0]  rsh;
		logic        infr;
		logic [15:0] rcrc;
		logic [1:0]  nb;
		logic [7:0]  cmd;
		logic [7:0]  acc;
		logic        lock;
		logic [63:0] uid;
		tbf_tx_t     txs;
		logic [6:0]  fc;
		logic [3:0]  tbit;
		logic [3:0]  tidx;
		logic [15:0] tcrc;
		logic [7:0]  hdr;
		logic        lm;
		logic        busy;
	} tbf_card_st_t;

	localparam tbf_card_st_t ST_RST = '{rxs: RX_HUNT, txs: TX_IDLE, default: '0};

	tbf_card_st_t st;
	tbf_card_st_t nxt;
	logic         por_s1;
	logic         por_s2;

	// Reply byte at a given index, checksum bytes inverted, low first
	function automatic logic [7:0] rsp_byte(input logic [3:0] idx, input logic [15:0] crc,
			input logic [7:0] hdr, input logic [63:0] uid);
		case (idx)
			4'h0:          rsp_byte = hdr;
			`TBF_RSP_CRC0: rsp_byte = ~crc[7:0];
			`TBF_RSP_LAST: rsp_byte = ~crc[15:8];
			default:       rsp_byte = uid[{3'(idx - 4'h1), 3'b000} +: 8];
		endcase
	endfunction

	// Line value that the transmitter shows in a given state
	function automatic logic tx_val(input tbf_tx_t s, input logic [7:0] d,
			input logic [3:0] b);
		case (s)
			TX_SOF0, TX_EOF: tx_val = 1'b0;
			TX_CHAR:         tx_val = tbf_char_bit(d, b);
			default:         tx_val = 1'b1;
		endcase
	endfunction

	// ------------------------------------------------------------------------
	// Reset synchroniser, outside the struct so reset cannot clear itself
	// ------------------------------------------------------------------------
	always_ff @(posedge lnk.link_clk) begin
		por_s1 <= lnk.pon_rst;
		por_s2 <= por_s1;
	end

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		logic       line;
		logic [6:0] mask;
		logic [9:0] ch;
		logic       bend;
		logic [3:0] last;
		tbf_tx_t    follow;
		logic [7:0] cur;
		logic       cmd_ok;
		line   = 1'b1;
		mask   = 7'h00;
		ch     = 10'h000;
		bend   = 1'b0;
		last   = 4'h0;
		follow = TX_IDLE;
		cur    = 8'h00;
		cmd_ok = 1'b0;
		nxt    = st;

		// Downlink sampling: modulated carrier is logic 0
		nxt.mod_s1 = lnk.mod;
		nxt.mod_s2 = st.mod_s1;
		line       = ~st.mod_s2;
		nxt.rprev  = line;
		// Rate crosses from the reader side; quasi-static, change only when idle
		nxt.rate_s1 = rate_i;
		nxt.rate_s2 = st.rate_s1;
		mask       = `TBF_ETU_MASK_CARD >> st.rate_s2;
		ch         = {line, st.rsh[9:1]};
		cmd_ok     = (st.cmd == `TBF_CMD_REQB) || (st.cmd == `TBF_CMD_READ_ID) ||
			(st.cmd == `TBF_CMD_SYSINFO);

		// Identifier caught once after reset and then held
		if (!st.lock) begin
			nxt.lock = 1'b1;
			nxt.uid  = {class_i, mfr_i, `TBF_UID_RSVD, feature_i, serial_i};
		end

		// Receiver: resync on every start edge, sample mid bit
		case (st.rxs)
			RX_HUNT: begin
				if (st.rprev && !line) begin
					nxt.rxs  = RX_CHAR;
					nxt.rcnt = 7'h00;
					nxt.rbit = 4'h0;
				end
			end
			RX_CHAR: begin
				nxt.rcnt = (st.rcnt == mask) ? 7'h00 : st.rcnt + 7'h01;
				if (st.rcnt == (mask >> 1)) begin
					nxt.rsh  = ch;
					nxt.rbit = st.rbit + 4'h1;
					if (st.rbit == `TBF_CHAR_LAST) begin
						nxt.rxs = RX_HUNT;
						if (ch == 10'h000 && !st.infr) begin
							nxt.infr = 1'b1;
							nxt.rcrc = `TBF_CRC_INIT;
							nxt.nb   = 2'h0;
						end else if (ch == 10'h000) begin
							nxt.infr = 1'b0;
							// Reply only to a whole, verified frame while silent
							if (st.nb == `TBF_MIN_BYTES && st.rcrc == `TBF_CRC_RESIDUE &&
									cmd_ok && st.txs == TX_IDLE) begin
								nxt.txs  = TX_GUARD;
								nxt.tbit = 4'h0;
								nxt.tidx = 4'h0;
								nxt.tcrc = `TBF_CRC_INIT;
								nxt.acc  = st.cmd;
								nxt.hdr  = (st.cmd == `TBF_CMD_REQB) ?
									`TBF_HDR_ATQB : `TBF_HDR_OK;
							end
						end else if (st.infr && !ch[0] && ch[9]) begin
							nxt.rcrc = tbf_crc_byte(st.rcrc, ch[8:1]);
							if (st.nb == 2'h0) begin
								nxt.cmd = ch[8:1];
							end
							if (st.nb != `TBF_MIN_BYTES) begin
								nxt.nb = st.nb + 2'h1;
							end
						end else begin
							nxt.infr = 1'b0;             // Framing error drops frame
						end
					end
				end
			end
			default: nxt.rxs = RX_HUNT;
		endcase

		// Transmitter: bits aligned to the free carrier divider
		nxt.fc = st.fc + 7'h01;
		bend   = (st.fc & mask) == mask;
		cur    = rsp_byte(st.tidx, st.tcrc, st.hdr, st.uid);
		case (st.txs)
			TX_GUARD: begin last = 4'(GUARD_BITS - 1); follow = TX_SOF0; end
			TX_SOF0:  begin last = `TBF_CHAR_LAST;     follow = TX_SOF1; end
			TX_SOF1:  begin last = `TBF_SOF1_LAST;     follow = TX_CHAR; end
			TX_CHAR:  begin
				last   = `TBF_CHAR_LAST;
				follow = (st.tidx == `TBF_RSP_LAST) ? TX_EOF : TX_CHAR;
			end
			TX_EOF:   begin last = `TBF_CHAR_LAST;     follow = TX_TAIL; end
			TX_TAIL:  begin last = 4'h0;               follow = TX_IDLE; end
			default:  begin last = 4'h0;               follow = TX_IDLE; end
		endcase
		if (bend && st.txs != TX_IDLE) begin
			nxt.tbit = st.tbit + 4'h1;
			if (st.txs == TX_CHAR && st.tbit != 4'h0 && st.tbit != `TBF_CHAR_LAST &&
					st.tidx < `TBF_RSP_CRC0) begin
				nxt.tcrc = tbf_crc_bit(st.tcrc, cur[3'(st.tbit - 4'h1)]);
			end
			if (st.tbit == last) begin
				nxt.tbit = 4'h0;
				nxt.txs  = follow;
				if (st.txs == TX_CHAR) begin
					nxt.tidx = st.tidx + 4'h1;
				end
			end
		end

		// BPSK: phase 0 for logic 1, so every value change flips phase
		cur      = rsp_byte(nxt.tidx, nxt.tcrc, nxt.hdr, nxt.uid);
		nxt.lm   = (nxt.txs != TX_IDLE) &
			(nxt.fc[`TBF_SC_BIT] ^ ~tx_val(nxt.txs, cur, nxt.tbit));
		nxt.busy = nxt.txs != TX_IDLE;
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge lnk.link_clk) begin
		if (por_s2) begin
			st <= ST_RST;
		end else begin
			st <= nxt;
		end
	end

	// Outputs straight from flops
	assign lnk.lm = st.lm;
	assign cmd_o  = st.acc;
	assign busy_o = st.busy;
endmodule

// ===== src/tbf_defines.svh
/*
 * Constants of the Type B frame coder: timing counts, framing lengths,
 * checksum values, command codes and identifier field positions.
 * Assumes it is included by bare name; guarded against double inclusion.
 */
`ifndef TBF_DEFINES_SVH
`define TBF_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TBF_ETU_MASK_CARD 7'h7F     // Carrier cycles per bit minus one, rate 0
`define TBF_ETU_MASK_RDR  8'hFF     // Reader clocks per bit minus one, rate 0
`define TBF_SC_BIT        3         // Counter bit giving carrier / 16
`define TBF_GUARD_BITS    4         // Subcarrier-only bits before SOF
`define TBF_PON_CYCLES    5'h10     // Power-on reset length in reader clocks
`define TBF_RSP_TIMEOUT   65536     // Reader wait for a reply, clocks
`define TBF_FLIP_RUN      5'h08     // Mismatch run that marks a phase flip
`define TBF_IDLE_MAX      6'h20     // Quiet clocks that mean subcarrier off
`define TBF_ON_MIN        7'h40     // Active clocks before demodulating
// ----------------------------------------------------------------------------
// Framing and checksum
// ----------------------------------------------------------------------------
`define TBF_CHAR_LAST     4'h9      // Ten bit times per character or delimiter
`define TBF_SOF1_LAST     4'h1      // Two stop bits after SOF
`define TBF_MIN_BYTES     2'h3
`define TBF_CRC_INIT      16'hFFFF
`define TBF_CRC_POLY      16'h8408
`define TBF_CRC_RESIDUE   16'hF0B8
// ----------------------------------------------------------------------------
// Commands and replies
// ----------------------------------------------------------------------------
`define TBF_CMD_REQB      8'h05
`define TBF_CMD_READ_ID   8'h31
`define TBF_CMD_SYSINFO   8'h32
`define TBF_HDR_ATQB      8'h50
`define TBF_HDR_OK        8'h00
`define TBF_RSP_CRC0      4'h9      // Index of first checksum byte
`define TBF_RSP_LAST      4'hA      // Eleven reply bytes
`define TBF_RSP_BYTES     4'hB
`define TBF_RDR_LAST      2'h2      // Command plus two checksum bytes
// ----------------------------------------------------------------------------
// Identifier layout
// ----------------------------------------------------------------------------
`define TBF_UID_FEAT_LSB  36
`define TBF_UID_RSVD_LSB  44
`define TBF_UID_MFR_LSB   48
`define TBF_UID_CLASS_LSB 56
`define TBF_UID_RSVD      4'h0
`endif

// ===== src/tbf_link_if.sv
/*
 * Link between reader and card: carrier clock, power-on reset, downlink
 * modulation and uplink load modulation. No clocking block.
 */
interface tbf_link_if;
	logic link_clk;  // Carrier, made by the reader
	logic pon_rst;   // Power-on reset, high while field not ready
	logic mod;       // High = modulated carrier (logic 0)
	logic lm;        // Card load modulation, BPSK subcarrier

	modport reader (output link_clk, output pon_rst, output mod, input lm);
	modport card   (input link_clk, input pon_rst, input mod, output lm);
endinterface

// ===== src/tbf_pkg.sv
/*
 * Types and checksum helpers shared by both link ends.
 * Assumes tbf_defines.svh is on the include path.
 */
`include "tbf_defines.svh"
package tbf_pkg;
	// ------------------------------------------------------------------------
	// State types
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		RX_HUNT = 2'h1,
		RX_CHAR = 2'h2
	} tbf_rx_t;

	typedef enum logic [7:0] {
		TX_IDLE   = 8'h01,
		TX_GUARD  = 8'h02,
		TX_SOF0   = 8'h04,
		TX_SOF1   = 8'h08,
		TX_CHAR   = 8'h10,
		TX_EOF    = 8'h20,
		TX_TAIL   = 8'h40,
		TX_LISTEN = 8'h80
	} tbf_tx_t;

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	// Reflected CCITT step, one bit, LSB first
	function automatic logic [15:0] tbf_crc_bit(input logic [15:0] crc, input logic b);
		tbf_crc_bit = {1'b0, crc[15:1]} ^ ((crc[0] ^ b) ? `TBF_CRC_POLY : 16'h0000);
	endfunction

	function automatic logic [15:0] tbf_crc_byte(input logic [15:0] crc, input logic [7:0] d);
		logic [15:0] c;
		c = crc;
		for (int i = 0; i < 8; i++) begin
			c = tbf_crc_bit(c, d[i]);
		end
		tbf_crc_byte = c;
	endfunction

	// Bit of a character: start 0, data LSB first, stop 1
	function automatic logic tbf_char_bit(input logic [7:0] d, input logic [3:0] idx);
		case (idx)
			4'h0:           tbf_char_bit = 1'b0;
			`TBF_CHAR_LAST: tbf_char_bit = 1'b1;
			default:        tbf_char_bit = d[3'(idx - 4'h1)];
		endcase
	endfunction
endpackage

// ===== src/tbf_reader.sv
/*
 * Reader end: makes the carrier and power-on reset, sends one command
 * frame on request and decodes the card's BPSK reply.
 * Assumes one card on the link; start_i is synchronous to clk_i.
 */
`include "tbf_defines.svh"
module tbf_reader
	import tbf_pkg::*;
#(
	parameter int RSP_TIMEOUT = `TBF_RSP_TIMEOUT
)
(
	// Clock and reset
	input  wire logic            clk_i,
	input  wire logic            srst_i,
	// Link
	tbf_link_if.reader           lnk,
	// Request
	input  wire logic [1:0]      rate_i,
	input  wire logic            start_i,
	input  wire logic [7:0]      cmd_i,
	// Reply
	output logic                 busy_o,
	output logic                 rsp_valid_o,
	output logic                 rsp_ok_o,
	output logic [71:0]          rsp_data_o
);
	if (RSP_TIMEOUT < 2) begin : g_chk
		$error("RSP_TIMEOUT must be at least 2");
	end
	localparam int TW = $clog2(RSP_TIMEOUT + 1);

	typedef struct packed {
		logic          lclk;
		logic [4:0]    por;
		logic          pon;
		logic [7:0]    fc;
		tbf_tx_t       txs;
		logic [3:0]    tbit;
		logic [1:0]    tidx;
		logic [7:0]    cmd;
		logic [15:0]   tcrc;
		logic          mod;
		logic          lm_s1;
		logic          lm_s2;
		logic [31:0]   dly;
		logic [4:0]    run;
		logic [5:0]    act;
		logic [6:0]    on;
		logic          lvl;
		logic          rprev;
		tbf_rx_t       rxs;
		logic [7:0]    rcnt;
		logic [3:0]    rbit;
		logic [9:0]    rsh;
		logic          infr;
		logic [15:0]   rcrc;
		logic [3:0]    nb;
		logic [71:0]   rsp;
		logic [TW-1:0] tout;
		logic          rsp_valid;
		logic          rsp_ok;
		logic          busy;
	} tbf_rdr_st_t;

	localparam tbf_rdr_st_t ST_RST = '{txs: TX_IDLE, rxs: RX_HUNT, pon: 1'b1, lvl: 1'b1,
		default: '0};

	tbf_rdr_st_t st;
	tbf_rdr_st_t nxt;

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		logic [7:0] mask;
		logic       mism;
		logic [9:0] ch;
		logic [7:0] cur;
		logic       v;
		mask = `TBF_ETU_MASK_RDR >> rate_i;
		mism = 1'b0;
		ch   = 10'h000;
		cur  = 8'h00;
		v    = 1'b1;
		nxt  = st;
		nxt.rsp_valid = 1'b0;

		// Carrier divider and power-on reset for the card
		nxt.lclk = ~st.lclk;
		if (st.por != `TBF_PON_CYCLES) begin
			nxt.por = st.por + 5'h01;
		end
		nxt.pon = nxt.por != `TBF_PON_CYCLES;

		// BPSK demodulation: compare with one subcarrier period ago
		nxt.lm_s1 = lnk.lm & ~st.pon;              // Card output unknown before its reset
		nxt.lm_s2 = st.lm_s1;
		nxt.dly   = {st.dly[30:0], st.lm_s2};
		nxt.act   = (st.lm_s2 != st.dly[0]) ? 6'h00 :
			((st.act == `TBF_IDLE_MAX) ? st.act : st.act + 6'h01);
		nxt.on    = (st.act == `TBF_IDLE_MAX) ? 7'h00 :
			((st.on == `TBF_ON_MIN) ? st.on : st.on + 7'h01);
		mism      = st.lm_s2 ^ st.dly[31];
		nxt.run   = mism ? st.run + 5'h01 : 5'h00;   // Wraps: one flip per period
		if (st.on != `TBF_ON_MIN) begin
			nxt.lvl = 1'b1;
		end else if (mism && st.run == `TBF_FLIP_RUN) begin
			nxt.lvl = ~st.lvl;
		end

		// Character receiver on the decoded level
		nxt.rprev = st.lvl;
		ch        = {st.lvl, st.rsh[9:1]};
		case (st.rxs)
			RX_HUNT: begin
				if (st.rprev && !st.lvl) begin
					nxt.rxs  = RX_CHAR;
					nxt.rcnt = 8'h00;
					nxt.rbit = 4'h0;
				end
			end
			RX_CHAR: begin
				nxt.rcnt = (st.rcnt == mask) ? 8'h00 : st.rcnt + 8'h01;
				if (st.rcnt == (mask >> 1)) begin
					nxt.rsh  = ch;
					nxt.rbit = st.rbit + 4'h1;
					if (st.rbit == `TBF_CHAR_LAST) begin
						nxt.rxs = RX_HUNT;
						if (ch == 10'h000 && !st.infr) begin
							nxt.infr = 1'b1;
							nxt.rcrc = `TBF_CRC_INIT;
							nxt.nb   = 4'h0;
						end else if (ch == 10'h000) begin
							nxt.infr = 1'b0;
							if (st.txs == TX_LISTEN) begin
								nxt.txs       = TX_IDLE;
								nxt.rsp_valid = 1'b1;
								nxt.rsp_ok    = st.nb == `TBF_RSP_BYTES &&
									st.rcrc == `TBF_CRC_RESIDUE;
							end
						end else if (st.infr && !ch[0] && ch[9]) begin
							nxt.rcrc = tbf_crc_byte(st.rcrc, ch[8:1]);
							if (st.nb < `TBF_RSP_CRC0) begin
								nxt.rsp = {ch[8:1], st.rsp[71:8]};
							end
							if (st.nb != 4'hF) begin
								nxt.nb = st.nb + 4'h1;
							end
						end else begin
							nxt.infr = 1'b0;
						end
					end
				end
			end
			default: nxt.rxs = RX_HUNT;
		endcase

		// Command transmitter and reply wait
		nxt.fc = st.fc + 8'h01;
		cur    = (st.tidx == 2'h0) ? st.cmd :
			((st.tidx == 2'h1) ? ~st.tcrc[7:0] : ~st.tcrc[15:8]);
		case (st.txs)
			TX_IDLE: begin
				// Start only once the card is out of reset and its subcarrier has
				// been still a while, so a reply's tail never overlaps a command
				if (start_i && !st.pon && st.act == `TBF_IDLE_MAX) begin
					nxt.txs  = TX_SOF0;
					nxt.fc   = 8'h00;
					nxt.tbit = 4'h0;
					nxt.tidx = 2'h0;
					nxt.cmd  = cmd_i;
					nxt.tcrc = `TBF_CRC_INIT;
				end
			end
			TX_LISTEN: begin
				nxt.tout = st.tout + TW'(1);
				if (st.tout == TW'(RSP_TIMEOUT - 1)) begin
					nxt.txs       = TX_IDLE;
					nxt.rsp_valid = 1'b1;
					nxt.rsp_ok    = 1'b0;
				end
			end
			TX_SOF0, TX_SOF1, TX_CHAR, TX_EOF: begin
				if ((st.fc & mask) == mask) begin
					nxt.tbit = st.tbit + 4'h1;
					if (st.txs == TX_CHAR && st.tidx == 2'h0 && st.tbit != 4'h0 &&
							st.tbit != `TBF_CHAR_LAST) begin
						nxt.tcrc = tbf_crc_bit(st.tcrc, cur[3'(st.tbit - 4'h1)]);
					end
					if (st.txs == TX_SOF1 && st.tbit == `TBF_SOF1_LAST) begin
						nxt.tbit = 4'h0;
						nxt.txs  = TX_CHAR;
					end else if (st.txs != TX_SOF1 && st.tbit == `TBF_CHAR_LAST) begin
						nxt.tbit = 4'h0;
						nxt.tidx = (st.txs == TX_CHAR) ? st.tidx + 2'h1 : st.tidx;
						if (st.txs == TX_SOF0) begin
							nxt.txs = TX_SOF1;
						end else if (st.txs == TX_EOF) begin
							nxt.txs  = TX_LISTEN;
							nxt.tout = '0;
						end else if (st.tidx == `TBF_RDR_LAST) begin
							nxt.txs = TX_EOF;
						end
					end
				end
			end
			default: nxt.txs = TX_IDLE;
		endcase

		// Modulated carrier for zeros; unmodulated after EOF and while listening
		case (nxt.txs)
			TX_SOF0, TX_EOF: v = 1'b0;
			TX_SOF1:         v = 1'b1;
			TX_CHAR: begin
				cur = (nxt.tidx == 2'h0) ? nxt.cmd :
					((nxt.tidx == 2'h1) ? ~nxt.tcrc[7:0] : ~nxt.tcrc[15:8]);
				v   = tbf_char_bit(cur, nxt.tbit);
			end
			default:         v = 1'b1;
		endcase
		nxt.mod  = ~v;
		nxt.busy = nxt.txs != TX_IDLE;
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st <= ST_RST;
		end else begin
			st <= nxt;
		end
	end

	// Outputs straight from flops
	assign lnk.link_clk = st.lclk;
	assign lnk.pon_rst  = st.pon;
	assign lnk.mod      = st.mod;
	assign busy_o       = st.busy;
	assign rsp_valid_o  = st.rsp_valid;
	assign rsp_ok_o     = st.rsp_ok;
	assign rsp_data_o   = st.rsp;
endmodule
